// ===== shared/scp_pkg.sv
package scp_pkg;

  // ==========================================================================
  // Register space
  // ==========================================================================
  localparam int ADDR_W = 10;
  localparam int REG_COUNT = 563;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h232;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_RDSEL = 10'h004;
  localparam logic [7:0] CFG_RESET = 8'h18;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int CFG_UNI_BIT = 7;
  localparam int CFG_LSB_BIT = 6;
  localparam int CFG_LONG_HI = 4;
  localparam int CFG_LONG_LO = 3;
  localparam int RDSEL_BIT = 0;
  localparam int UPDATE_BIT = 0;

  // ==========================================================================
  // Instruction word
  // ==========================================================================
  localparam int INSTR_W = 16;
  localparam int RW_BIT = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 13;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] LEN_ONE = 2'h0;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
  localparam logic [7:0] SCLK_HALF_LAST = 8'(SCLK_HALF_CYC - 1);
  localparam int CS_GAP_NS = 80;
  localparam int CS_GAP_CYC = (CS_GAP_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam logic [7:0] CS_GAP_LAST = 8'(CS_GAP_CYC - 1);

  // One serial bit enters a 16-bit shift word in the selected bit order.
  function automatic logic [15:0] scp_shift_in(input logic [15:0] w,
                                               input logic b,
                                               input logic lsb);
    scp_shift_in = lsb ? {b, w[15:1]} : {w[14:0], b};
  endfunction

  // The byte that was just completed inside a shift word.
  function automatic logic [7:0] scp_byte_of(input logic [15:0] w,
                                             input logic lsb);
    scp_byte_of = lsb ? w[15:8] : w[7:0];
  endfunction

endpackage

// ===== shared/scp_if.sv
`timescale 1ns/1ps
interface scp_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_o;
  logic host_sdio_oe_n;
  logic dev_sdio_o;
  logic dev_sdio_oe_n;
  logic dev_sdo_o;
  logic dev_sdo_oe_n;
  logic sdio;
  logic separate_serial_out;

  // Wire levels; an undriven pin settles low.
  assign sdio = !dev_sdio_oe_n ? dev_sdio_o :
                !host_sdio_oe_n ? host_sdio_o : 1'b0;
  assign separate_serial_out = !dev_sdo_oe_n ? dev_sdo_o : 1'b0;

  modport device (
    input sclk,
    input cs_n,
    input sdio,
    output dev_sdio_o,
    output dev_sdio_oe_n,
    output dev_sdo_o,
    output dev_sdo_oe_n
  );

  modport host (
    output sclk,
    output cs_n,
    output host_sdio_o,
    output host_sdio_oe_n,
    input sdio,
    input separate_serial_out
  );
endinterface

// ===== src/scp_device.sv
`timescale 1ns/1ps
module scp_device
  import scp_pkg::*;
(
  // Serial link
  scp_if.device link,
  // Reset, level, caught on the serial clock
  input wire logic sys_rst,
  // Live register read port
  input wire logic [ADDR_W-1:0] live_index,
  output logic [7:0] live_data,
  output logic update_pulse
);

  // ==========================================================================
  // Types and state
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10,
    ST_DONE = 2'b11
  } scp_state_type;

  scp_state_type state_r;
  scp_state_type eff_state;
  logic [3:0] bit_r;
  logic [3:0] eff_bit;
  logic [15:0] sh_r;
  logic [15:0] shifted;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [1:0] left_r;
  logic stream_r;
  logic gap_r;
  logic rst_meta_r;
  logic rst_r;
  logic restart;
  logic lsb;
  logic uni;
  logic byte_end;
  logic last_byte;
  logic wr_fire;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic out_r;
  logic drive_r;
  logic drive_ok;
  logic update_r;
  logic upd_fire;
  logic [7:0] buf_r [0:REG_COUNT-1];
  logic [7:0] live_r [0:REG_COUNT-1];

  // ==========================================================================
  // Reset and chip-select gap
  // ==========================================================================
  // The serial clock only runs inside frames, so reset must be held while
  // the master toggles the clock at least three times.
  always_ff @(posedge link.sclk) begin
    rst_meta_r <= sys_rst;
    rst_r <= rst_meta_r;
  end

  // Chip select high leaves a mark that the next rising edge inspects; the
  // clock is stopped outside frames, so the rise itself is caught as a set.
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      gap_r <= 1'b1;
    end else begin
      gap_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  assign lsb = buf_r[ADDR_CFG][CFG_LSB_BIT];
  assign uni = buf_r[ADDR_CFG][CFG_UNI_BIT];

  // A gap inside a byte, after a finished cycle, or inside a stream opens
  // a fresh instruction with this edge's bit as its first.
  assign restart = gap_r && (bit_r[2:0] != 3'h0 || state_r == ST_DONE ||
                             stream_r);
  assign eff_state = restart ? ST_INSTR : state_r;
  assign eff_bit = restart ? 4'h0 : bit_r;
  assign shifted = scp_shift_in(restart ? 16'h0000 : sh_r, link.sdio,
                                lsb);
  assign byte_end = eff_bit[2:0] == BYTE_LAST_BIT;
  assign last_byte = stream_r ? (addr_r == ADDR_LAST) :
                     (left_r == 2'h0);
  assign wr_fire = !rst_r && eff_state == ST_WRITE && byte_end;
  assign wr_byte = scp_byte_of(shifted, lsb);
  assign upd_fire = wr_fire && addr_r == ADDR_LAST && wr_byte[UPDATE_BIT];

  always_comb begin
    if (lsb) begin
      addr_nxt = addr_r + 10'h001;
    end else if (addr_r == ADDR_CFG) begin
      addr_nxt = ADDR_LAST;
    end else begin
      addr_nxt = addr_r - 10'h001;
    end
  end

  // ==========================================================================
  // Transaction sequencer
  // ==========================================================================
  always_ff @(posedge link.sclk) begin
    if (rst_r) begin
      state_r <= ST_INSTR;
      bit_r <= 4'h0;
      sh_r <= 16'h0000;
      addr_r <= ADDR_CFG;
      left_r <= 2'h0;
      stream_r <= 1'b0;
    end else begin
      unique case (eff_state)
        ST_INSTR: begin
          sh_r <= shifted;
          if (eff_bit == INSTR_LAST_BIT) begin
            addr_r <= shifted[ADDR_W-1:0];
            left_r <= shifted[LEN_HI:LEN_LO];
            stream_r <= shifted[LEN_HI:LEN_LO] == LEN_STREAM;
            state_r <= shifted[RW_BIT] ? ST_READ : ST_WRITE;
            bit_r <= 4'h0;
          end else begin
            stream_r <= 1'b0;
            state_r <= ST_INSTR;
            bit_r <= eff_bit + 4'h1;
          end
        end
        ST_WRITE, ST_READ: begin
          sh_r <= shifted;
          if (byte_end) begin
            bit_r <= 4'h0;
            if (last_byte) begin
              state_r <= ST_DONE;
            end else begin
              addr_r <= addr_nxt;
              left_r <= left_r - 2'h1;
            end
          end else begin
            bit_r <= eff_bit + 4'h1;
          end
        end
        ST_DONE: begin
          bit_r <= 4'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Staging buffer and live registers
  // ==========================================================================
  // Only the live copy changes on update, and it changes all at once, so
  // the clock logic never sees a half-written configuration.
  always_ff @(posedge link.sclk) begin
    if (rst_r) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        buf_r[i] <= BYTE_ZERO;
      end
      buf_r[ADDR_CFG] <= CFG_RESET;
      update_r <= 1'b0;
    end else begin
      update_r <= 1'b0;
      if (wr_fire && addr_r < ADDR_LAST) begin
        buf_r[addr_r] <= wr_byte;
      end
      if (upd_fire) begin
        update_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge link.sclk) begin
    if (rst_r) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        live_r[i] <= BYTE_ZERO;
      end
      live_r[ADDR_CFG] <= CFG_RESET;
    end else if (upd_fire) begin
      // Copy on the edge that completes the update byte: the serial clock
      // stops once the frame ends, so a later edge may never come.
      for (int i = 0; i < REG_COUNT; i++) begin
        live_r[i] <= buf_r[i];
      end
    end
  end

  assign update_pulse = update_r;
  assign live_data = (live_index < ADDR_LAST) ? live_r[live_index] :
                     BYTE_ZERO;

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    if (addr_r >= ADDR_LAST) begin
      rd_byte = BYTE_ZERO;
    end else if (buf_r[ADDR_RDSEL][RDSEL_BIT]) begin
      rd_byte = live_r[addr_r];
    end else begin
      rd_byte = buf_r[addr_r];
    end
  end

  // Bits move on the falling edge, half a period ahead of the master's
  // sampling edge.
  always_ff @(negedge link.sclk) begin
    if (rst_r) begin
      out_r <= 1'b0;
    end else begin
      if (lsb) begin
        out_r <= rd_byte[bit_r[2:0]];
      end else begin
        out_r <= rd_byte[3'h7 - bit_r[2:0]];
      end
    end
  end

  // Chip select rising drops the drive at once; a stream read that the
  // master ends early would otherwise carry it into the next frame.
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      drive_r <= 1'b0;
    end else if (rst_r) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= state_r == ST_READ && !gap_r;
    end
  end

  // A new frame starting over a stale read must not fight the master.
  assign drive_ok = !link.cs_n && drive_r && !restart;
  assign link.dev_sdio_o = out_r;
  assign link.dev_sdio_oe_n = !(drive_ok && !uni);
  assign link.dev_sdo_o = out_r;
  assign link.dev_sdo_oe_n = !(drive_ok && uni);

endmodule // scp_device

// ===== src/scp_host.sv
`timescale 1ns/1ps
module scp_host
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link
  scp_if.host link,
  // Port configuration known to software
  input wire logic lsb_first,
  input wire logic sdo_mode,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_count,
  input wire logic [ADDR_W-1:0] cmd_addr,
  // Write bytes
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // Read bytes and status
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP = 2'b10
  } scp_hstate_type;

  scp_hstate_type state_r;
  logic [7:0] cnt_r;
  logic [2:0] bit_r;
  logic [1:0] instr_r;
  logic [8:0] left_r;
  logic read_r;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic sclk_r;
  logic cs_n_r;
  logic mosi_r;
  logic oe_n_r;
  logic wr_take_r;
  logic rd_valid_r;
  logic [7:0] rd_data_r;
  logic done_r;
  logic sdio_meta_r;
  logic sdio_sync_r;
  logic sdo_meta_r;
  logic sdo_sync_r;
  logic sdi;
  logic [1:0] len_code;
  logic [15:0] instr;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  always_ff @(posedge clk) begin
    sdio_meta_r <= link.sdio;
    sdio_sync_r <= sdio_meta_r;
    sdo_meta_r <= link.separate_serial_out;
    sdo_sync_r <= sdo_meta_r;
  end

  assign sdi = sdo_mode ? sdo_sync_r : sdio_sync_r;

  // ==========================================================================
  // Decode
  // ==========================================================================
  assign len_code = (cmd_count > 8'h03) ? LEN_STREAM :
                    2'(cmd_count - 8'h01);
  assign instr = {cmd_read, len_code, 3'h0, cmd_addr};
  assign sh_nxt = lsb_first ? {1'b0, sh_r[15:1]} : {sh_r[14:0], 1'b0};
  assign rx_nxt = lsb_first ? {sdi, rx_r[7:1]} : {rx_r[6:0], sdi};

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= H_IDLE;
      cnt_r <= 8'h00;
      bit_r <= 3'h0;
      instr_r <= 2'h0;
      left_r <= 9'h000;
      read_r <= 1'b0;
      sh_r <= 16'h0000;
      rx_r <= 8'h00;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      mosi_r <= 1'b0;
      oe_n_r <= 1'b1;
      wr_take_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      wr_take_r <= 1'b0;
      rd_valid_r <= 1'b0;
      done_r <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          if (cmd_valid) begin
            cs_n_r <= 1'b0;
            oe_n_r <= 1'b0;
            sh_r <= instr;
            mosi_r <= lsb_first ? instr[0] : instr[15];
            read_r <= cmd_read;
            left_r <= (cmd_count == 8'h00) ? 9'h001 : {1'b0, cmd_count};
            instr_r <= 2'h2;
            bit_r <= 3'h0;
            cnt_r <= 8'h00;
            state_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == SCLK_HALF_LAST && !sclk_r) begin
            sclk_r <= 1'b1;
            cnt_r <= 8'h00;
            if (instr_r == 2'h0 && read_r) begin
              rx_r <= rx_nxt;
            end
          end else if (cnt_r == SCLK_HALF_LAST) begin
            sclk_r <= 1'b0;
            cnt_r <= 8'h00;
            bit_r <= bit_r + 3'h1;
            sh_r <= sh_nxt;
            mosi_r <= lsb_first ? sh_nxt[0] : sh_nxt[15];
            if (bit_r == BYTE_LAST_BIT) begin
              if (instr_r != 2'h0) begin
                instr_r <= instr_r - 2'h1;
              end else begin
                left_r <= left_r - 9'h001;
                rd_valid_r <= read_r;
                rd_data_r <= rx_r;
              end
              if (instr_r == 2'h0 && left_r == 9'h001) begin
                cs_n_r <= 1'b1;
                oe_n_r <= 1'b1;
                state_r <= H_GAP;
              end else if (instr_r != 2'h2 && read_r) begin
                oe_n_r <= 1'b1;
              end else if (instr_r != 2'h2) begin
                sh_r <= lsb_first ? {8'h00, wr_data} : {wr_data, 8'h00};
                mosi_r <= lsb_first ? wr_data[0] : wr_data[7];
                wr_take_r <= 1'b1;
              end
            end
          end
        end
        H_GAP: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == CS_GAP_LAST) begin
            cnt_r <= 8'h00;
            done_r <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready = state_r == H_IDLE;
  assign wr_take = wr_take_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign done = done_r;
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.host_sdio_o = mosi_r;
  assign link.host_sdio_oe_n = oe_n_r;

endmodule // scp_host

// ===== testbench/scp_chk.sv
`timescale 1ns/1ps
// ============================================================
// Link checker
// ============================================================
module scp_chk (
  // Clocks and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dev_rst,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe_n,
  input wire logic dev_sdo_oe_n
);
  logic [7:0] edge_r;

  // Rising serial edges in the current frame; cleared while deselected.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_r <= 8'h00;
    end else begin
      edge_r <= edge_r + 8'h01;
    end
  end

  AST_IDLE_HIZ: assert property (@(posedge clk) disable iff (dev_rst)
    cs_n |-> dev_sdio_oe_n && dev_sdo_oe_n)
    else $error("data pin driven while deselected");
  AST_NO_CONTEND: assert property (@(posedge clk) disable iff (dev_rst)
    !(!dev_sdio_oe_n && !host_sdio_oe_n))
    else $error("both ends drive the shared pin");
  AST_QUIET_INSTR: assert property (@(posedge sclk) disable iff (dev_rst)
    edge_r < 8'h10 |-> dev_sdio_oe_n && dev_sdo_oe_n)
    else $error("device drives during the instruction");
  AST_ONE_PIN: assert property (@(posedge sclk) disable iff (dev_rst)
    !dev_sdio_oe_n |-> dev_sdo_oe_n)
    else $error("read data on both pins");
  AST_READ_HOLD: assert property (@(posedge clk) disable iff (dev_rst)
    sclk && $past(sclk) && !dev_sdio_oe_n |-> $stable(dev_sdio_o))
    else $error("read bit moved while serial clock high");
  AST_CS_LEAD: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(sclk) |-> !cs_n && !$past(cs_n, 4))
    else $error("serial clock rose without chip select lead");
  AST_SCLK_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  AST_HIGH_TIME: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(sclk) |=> sclk [*7] ##1 !sclk)
    else $error("serial clock high time wrong");
  AST_HOST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    sclk && !host_sdio_oe_n |-> $stable(host_sdio_o))
    else $error("write bit moved while serial clock high");
  AST_BYTE_END: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(cs_n) |-> $past(edge_r[2:0]) == 3'h0 && $past(edge_r) >= 8'h18)
    else $error("frame ended off a byte boundary");

  C_SDIO_READ: cover property (@(posedge clk) !dev_sdio_oe_n);
  C_SDO_READ: cover property (@(posedge clk) !dev_sdo_oe_n);
  C_LONG: cover property (@(posedge clk) $rose(cs_n) && $past(edge_r) > 8'h28);
endmodule // scp_chk

// ===== testbench/tb_serial_control_port.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_serial_control_port;
  import scp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic dev_rst = 1'b1;
  logic lsb_first = 1'b0;
  logic sdo_mode = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_count = 8'h01;
  logic [ADDR_W-1:0] cmd_addr = 10'h000;
  logic [7:0] wr_data = 8'h00;
  logic [ADDR_W-1:0] live_index = 10'h000;
  logic cmd_ready, wr_take, rd_valid, done, update_pulse;
  logic [7:0] rd_data, live_data, g;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];
  int n_errors = 0;
  int checked = 0;
  int n_upd = 0;
  int u0;
  logic s;

  scp_if link_a ();
  scp_if link_b ();
  scp_host u_scp_host (.clk(clk), .sys_rst(sys_rst), .link(link_a.host),
    .lsb_first(lsb_first), .sdo_mode(sdo_mode), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_count(cmd_count),
    .cmd_addr(cmd_addr), .wr_data(wr_data), .wr_take(wr_take),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
  scp_device u_scp_device (.link(link_a.device), .sys_rst(dev_rst),
    .live_index(live_index), .live_data(live_data),
    .update_pulse(update_pulse));
  // The second device faces the bench driver, which breaks framing on purpose.
  scp_device u_scp_device_b (.link(link_b.device), .sys_rst(dev_rst),
    .live_index(10'h000), .live_data(), .update_pulse());
  scp_chk u_scp_chk (.clk(clk), .sys_rst(sys_rst), .dev_rst(dev_rst),
    .sclk(link_a.sclk), .cs_n(link_a.cs_n), .host_sdio_o(link_a.host_sdio_o),
    .host_sdio_oe_n(link_a.host_sdio_oe_n), .dev_sdio_o(link_a.dev_sdio_o),
    .dev_sdio_oe_n(link_a.dev_sdio_oe_n), .dev_sdo_oe_n(link_a.dev_sdo_oe_n));

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge update_pulse) begin
    n_upd++;
  end

  // ============================================================
  // Tasks
  // ============================================================
  task automatic complete_run();
    $display("n_errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic put(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      wbuf[i] = d[63-8*i -: 8];
    end
  endtask

  task automatic cmpn(input logic [63:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      `CHK(rbuf[i], e[63-8*i -: 8])
    end
  endtask

  task automatic xfer(input logic rd, input logic [7:0] n,
                      input logic [9:0] a);
    int k = 0;
    int w = 0;
    int t = 0;
    @(posedge clk);
    `CHK(cmd_ready, 1'b1)
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_count <= n;
    cmd_addr <= a;
    wr_data <= wbuf[0];
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && t < 4000) begin
      @(posedge clk);
      t++;
      if (wr_take === 1'b1) begin
        w++;
        wr_data <= wbuf[w[2:0]];
      end
      if (rd_valid === 1'b1) begin
        rbuf[k[2:0]] = rd_data;
        k++;
      end
    end
    if (t >= 4000) n_errors++;
  endtask

  // One bench serial bit: low one cycle, high two, a 15 ns period.
  task automatic bbit(input logic b, output logic q);
    @(posedge clk);
    link_b.sclk <= 1'b0;
    link_b.host_sdio_o <= b;
    @(posedge clk);
    q = link_b.sdio;
    link_b.sclk <= 1'b1;
    @(posedge clk);
  endtask

  task automatic bsend(input logic [31:0] w, input int n,
                       output logic [7:0] q);
    logic b;
    for (int i = n - 1; i >= 0; i--) begin
      bbit(w[i], b);
      q = {q[6:0], b};
    end
  endtask

  task automatic bcs(input logic v);
    @(posedge clk);
    link_b.sclk <= 1'b0;
    link_b.cs_n <= v;
    link_b.host_sdio_oe_n <= v;
    repeat (3) @(posedge clk);
  endtask

  task automatic bread(input logic [9:0] a, output logic [7:0] q);
    bcs(1'b0);
    bsend({22'h000020, a}, 16, q);
    @(posedge clk);
    link_b.host_sdio_oe_n <= 1'b1;
    bsend(32'h0, 8, q);
    bcs(1'b1);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // ============================================================
  // Tests
  // ============================================================
  initial begin
    link_b.sclk = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.host_sdio_o = 1'b0;
    link_b.host_sdio_oe_n = 1'b1;
    put(64'h0);
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // Both devices need serial edges to take the reset in.
    for (int i = 0; i < 4; i++) bbit(1'b0, s);
    xfer(1'b1, 8'h01, ADDR_CFG);
    @(posedge clk);
    dev_rst <= 1'b0;
    // Two bench serial edges carry the release through the second device's
    // synchroniser; the first device's throwaway frame ends mid-byte and is dropped.
    for (int i = 0; i < 2; i++) bbit(1'b0, s);
    xfer(1'b1, 8'h01, ADDR_CFG);
    xfer(1'b1, 8'h01, ADDR_CFG);
    `CHK(rbuf[0], CFG_RESET)
    put(64'hA1B2C3_0000000000);
    xfer(1'b0, 8'h03, 10'h012);
    xfer(1'b1, 8'h02, 10'h011);
    cmpn(64'hB2C3_000000000000, 2);
    @(posedge clk);
    live_index <= 10'h012;
    @(posedge clk);
    `CHK(live_data, BYTE_ZERO)
    u0 = n_upd;
    put(64'h01_00000000000000);
    xfer(1'b0, 8'h01, ADDR_LAST);
    `CHK(n_upd - u0, 1)
    `CHK(live_data, 8'hA1)
    live_index <= 10'h010;
    @(posedge clk);
    `CHK(live_data, 8'hC3)
    xfer(1'b1, 8'h01, ADDR_LAST);
    `CHK(rbuf[0], BYTE_ZERO)
    xfer(1'b0, 8'h01, ADDR_RDSEL);
    put(64'h55_00000000000000);
    xfer(1'b0, 8'h01, 10'h012);
    xfer(1'b1, 8'h01, 10'h012);
    `CHK(rbuf[0], 8'hA1)
    put(64'h0);
    xfer(1'b0, 8'h01, ADDR_RDSEL);
    xfer(1'b1, 8'h01, 10'h012);
    `CHK(rbuf[0], 8'h55)
    put(64'h11223318_00EE0000);
    xfer(1'b0, 8'h06, 10'h003);
    xfer(1'b1, 8'h04, 10'h003);
    cmpn(64'h11223318_00000000, 4);
    xfer(1'b1, 8'h01, 10'h231);
    `CHK(rbuf[0], BYTE_ZERO)
    put(64'hDB_00000000000000);
    xfer(1'b0, 8'h01, ADDR_CFG);
    lsb_first <= 1'b1;
    sdo_mode <= 1'b1;
    put(64'h5AC3_000000000000);
    xfer(1'b0, 8'h02, 10'h020);
    xfer(1'b1, 8'h01, 10'h021);
    `CHK(rbuf[0], 8'hC3)
    put(64'h18_00000000000000);
    xfer(1'b0, 8'h01, ADDR_CFG);
    lsb_first <= 1'b0;
    sdo_mode <= 1'b0;
    xfer(1'b1, 8'h01, ADDR_CFG);
    `CHK(rbuf[0], CFG_RESET)
    // Bench-driven link: mid-byte abort, stalls and abandon.
    bcs(1'b0);
    bsend(32'h0030, 16, g);
    bsend(32'h5, 4, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'h00305A, 24, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'h00, 8, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'h31, 8, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'hA5, 8, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'h203311, 24, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'h7, 3, g);
    bcs(1'b1);
    bcs(1'b0);
    bsend(32'h003277, 24, g);
    bcs(1'b1);
    bread(10'h030, g);
    `CHK(g, 8'h5A)
    bread(10'h031, g);
    `CHK(g, 8'hA5)
    bread(10'h033, g);
    `CHK(g, 8'h11)
    bread(10'h032, g);
    `CHK(g, 8'h77)
    complete_run();
  end
endmodule // tb_serial_control_port
